// ### hdl/sot_event_tally.sv
// Derived event tally for retired op profiling samples
`include "sot_params.svh"

module sot_event_tally (
    input wire logic clk,
    input wire logic reset,
    // Sample from the op sampling hardware
    input wire logic sampleValid,
    input wire logic opIsBranch,
    input wire logic branchMispredicted,
    input wire logic branchTaken,
    input wire logic opIsReturn,
    input wire logic returnMispredicted,
    input wire logic opIsResync,
    input wire logic opIsLoad,
    input wire logic opIsStore,
    input wire logic firstLevelXlatMiss,
    input wire logic secondLevelXlatMiss,
    input wire logic linearAddressValid,
    input wire logic dataCacheMiss,
    input wire logic misalignedAccess,
    input wire logic loadBankConflict,
    input wire logic storeForwardedToLoad,
    input wire logic storeForwardCancelled,
    input wire logic uncachedAccess,
    input wire logic writeCombiningAccess,
    input wire logic lockedOperation,
    input wire logic missBufferHit,
    input wire logic firstLevelHit2mPage,
    input wire logic firstLevelHit1gPage,
    input wire logic secondLevelHit2mPage,
    input wire sot_pkg::sot_latency_type missLatencyCycles,
    input wire sot_pkg::sot_source_type memoryDataSource,
    input wire sot_pkg::sot_qualifier_type memorySourceQualifier,
    input wire logic remoteNodeRequest,
    input wire logic ownedStateHit,
    // Count read port
    input wire sot_pkg::sot_event_type countSelect,
    output sot_pkg::sot_count_type countValue
);
    import sot_pkg::*;

    // ------------------------------------------------------------
    // Per event hit and amount
    // ------------------------------------------------------------
    logic [`SOT_EVENT_COUNT-1:0] eventHit;
    sot_count_type latencyAmount;
    sot_count_type eventTotal [`SOT_EVENT_COUNT];

    // Latency widened to the sum width
    assign latencyAmount = {{(`SOT_COUNT_WIDTH-`SOT_LAT_WIDTH){1'h0}}, missLatencyCycles};

    // ------------------------------------------------------------
    // Common qualifiers
    // ------------------------------------------------------------
    logic memOp;
    logic xlatTried;
    logic missingLoad;
    logic mcValid;
    logic mcLocal;
    logic mcRemote;
    logic srcShared;
    logic srcCore;
    logic srcDram;
    logic srcOther;

    // Load or store gate for the translation, cache and page size events, SOT_EV_XL1_HIT through SOT_EV_XL2_PAGE_2M
    assign memOp = opIsLoad | opIsStore;
    // Translation attempted on a memory op
    assign xlatTried = memOp & linearAddressValid;
    // Load that missed the data cache
    assign missingLoad = opIsLoad & dataCacheMiss;
    // Controller data are meaningful only for a missing load with qualifier clear
    assign mcValid = missingLoad & (memorySourceQualifier == `SOT_QUAL_VALID);
    // Locality from the remote node flag
    assign mcLocal = mcValid & ~remoteNodeRequest;
    assign mcRemote = mcValid & remoteNodeRequest;
    // Data source decode
    assign srcShared = memoryDataSource == `SOT_SRC_SHARED_CACHE;
    assign srcCore = memoryDataSource == `SOT_SRC_OTHER_CORE;
    assign srcDram = memoryDataSource == `SOT_SRC_DRAM;
    assign srcOther = memoryDataSource == `SOT_SRC_OTHER;

    // ------------------------------------------------------------
    // Branch, return and resync group
    // ------------------------------------------------------------
    // The flags mark architectural branches only, so microcode branches never count
    assign eventHit[SOT_EV_BRANCH] = opIsBranch;
    assign eventHit[SOT_EV_BRANCH_MISP] = opIsBranch & branchMispredicted;
    assign eventHit[SOT_EV_BRANCH_TAKEN] = opIsBranch & branchTaken;
    assign eventHit[SOT_EV_BRANCH_TAKEN_MISP] = opIsBranch & branchTaken & branchMispredicted;
    assign eventHit[SOT_EV_RETURN] = opIsReturn;
    assign eventHit[SOT_EV_RETURN_MISP] = opIsReturn & returnMispredicted;
    assign eventHit[SOT_EV_RESYNC] = opIsResync;

    // ------------------------------------------------------------
    // Load and store group
    // ------------------------------------------------------------
    // Basic memory op counts
    assign eventHit[SOT_EV_MEM_OP] = memOp;
    assign eventHit[SOT_EV_LOAD] = opIsLoad;
    assign eventHit[SOT_EV_STORE] = opIsStore;

    // Translation outcome
    assign eventHit[SOT_EV_XL1_HIT] = xlatTried & ~firstLevelXlatMiss;
    assign eventHit[SOT_EV_XL1_MISS_XL2_HIT] = memOp & firstLevelXlatMiss & ~secondLevelXlatMiss;
    assign eventHit[SOT_EV_XL1_MISS_XL2_MISS] = memOp & firstLevelXlatMiss & secondLevelXlatMiss;

    // Single-flag cache conditions
    assign eventHit[SOT_EV_DC_MISS] = memOp & dataCacheMiss;
    assign eventHit[SOT_EV_DC_HIT] = memOp & ~dataCacheMiss;
    assign eventHit[SOT_EV_MISALIGNED] = memOp & misalignedAccess;
    assign eventHit[SOT_EV_BANK_CONFLICT] = memOp & loadBankConflict;
    assign eventHit[SOT_EV_STORE_FWD] = memOp & storeForwardedToLoad;
    assign eventHit[SOT_EV_FWD_CANCEL] = memOp & storeForwardCancelled;
    assign eventHit[SOT_EV_UNCACHED] = memOp & uncachedAccess;
    assign eventHit[SOT_EV_WRITE_COMB] = memOp & writeCombiningAccess;
    assign eventHit[SOT_EV_LOCKED] = memOp & lockedOperation;
    assign eventHit[SOT_EV_MISS_BUF_HIT] = memOp & missBufferHit;

    // First level page size, valid only after a translation attempt
    assign eventHit[SOT_EV_XL1_PAGE_4K] = xlatTried & ~firstLevelHit2mPage & ~firstLevelHit1gPage;
    assign eventHit[SOT_EV_XL1_PAGE_2M] = xlatTried & firstLevelHit2mPage;
    assign eventHit[SOT_EV_XL1_PAGE_1G] = xlatTried & firstLevelHit1gPage;

    // Second level page size, valid only when the first level missed
    assign eventHit[SOT_EV_XL2_PAGE_4K] = xlatTried & firstLevelXlatMiss & ~secondLevelXlatMiss &
                                          ~secondLevelHit2mPage;
    assign eventHit[SOT_EV_XL2_PAGE_2M] = xlatTried & firstLevelXlatMiss & ~secondLevelXlatMiss &
                                          secondLevelHit2mPage;

    // Miss latency sum, loads only
    assign eventHit[SOT_EV_MISS_LOAD_LAT] = missingLoad;

    // ------------------------------------------------------------
    // Memory controller group
    // ------------------------------------------------------------
    // Locality regardless of source
    assign eventHit[SOT_EV_MC_LOCAL] = mcLocal;
    assign eventHit[SOT_EV_MC_REMOTE] = mcRemote;

    // Locality by source; the shared cache has no remote form
    assign eventHit[SOT_EV_MC_LOCAL_SHARED] = mcLocal & srcShared;
    assign eventHit[SOT_EV_MC_LOCAL_CORE] = mcLocal & srcCore;
    assign eventHit[SOT_EV_MC_REMOTE_CACHE] = mcRemote & srcCore;
    assign eventHit[SOT_EV_MC_LOCAL_DRAM] = mcLocal & srcDram;
    assign eventHit[SOT_EV_MC_REMOTE_DRAM] = mcRemote & srcDram;
    assign eventHit[SOT_EV_MC_LOCAL_OTHER] = mcLocal & srcOther;
    assign eventHit[SOT_EV_MC_REMOTE_OTHER] = mcRemote & srcOther;

    // Line state when another core supplied the data
    assign eventHit[SOT_EV_MC_MODIFIED] = mcValid & srcCore & ~ownedStateHit;
    assign eventHit[SOT_EV_MC_OWNED] = mcValid & srcCore & ownedStateHit;

    // Latency sums by locality
    assign eventHit[SOT_EV_MC_LOCAL_LAT] = mcLocal;
    assign eventHit[SOT_EV_MC_REMOTE_LAT] = mcRemote;

    // ------------------------------------------------------------
    // Counter bank
    // ------------------------------------------------------------
    // One saturating accumulator per event; the three latency entries add the
    // latency field, every other entry adds one. All update on the same edge.
    generate
        for (genvar ev = 0; ev < `SOT_EVENT_COUNT; ev++) begin : gen_event
            localparam bit isLatency = (ev == int'(SOT_EV_MISS_LOAD_LAT)) ||
                                       (ev == int'(SOT_EV_MC_LOCAL_LAT)) ||
                                       (ev == int'(SOT_EV_MC_REMOTE_LAT));
            sot_count_type stepValue;
            logic stepEnable;

            // Amount and enable for this entry
            assign stepValue = isLatency ? latencyAmount : sot_count_type'(1);
            assign stepEnable = sampleValid & eventHit[ev];

            sot_sat_accum u_accum (
                .clk(clk),
                .reset(reset),
                .addEnable(stepEnable),
                .addValue(stepValue),
                .total(eventTotal[ev])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    sot_count_type selectedTotal;

    // Out of range selects read zero
    assign selectedTotal = (countSelect < `SOT_EVENT_COUNT) ? eventTotal[countSelect] : `SOT_COUNT_RESET;

    // Registered read data
    always_ff @(posedge clk) begin
        if (reset) begin
            countValue <= `SOT_COUNT_RESET;
        end else begin
            countValue <= selectedTotal;
        end
    end

endmodule : sot_event_tally

// ### hdl/sot_params.svh
// Widths, codes and reset values for the sampled op event tally
`ifndef SOT_PARAMS_SVH
`define SOT_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SOT_COUNT_WIDTH 32
`define SOT_LAT_WIDTH 16
`define SOT_SRC_WIDTH 3
`define SOT_QUAL_WIDTH 1
`define SOT_SEL_WIDTH 6
`define SOT_EVENT_COUNT 42

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SOT_COUNT_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Data source codes and qualifier
// ----------------------------------------------------------------
`define SOT_SRC_SHARED_CACHE 3'h1
`define SOT_SRC_OTHER_CORE 3'h2
`define SOT_SRC_DRAM 3'h3
`define SOT_SRC_OTHER 3'h7
`define SOT_QUAL_VALID 1'h0

`endif

// ### hdl/sot_pkg.sv
// Types shared by the sampled op event tally
`include "sot_params.svh"

package sot_pkg;

    typedef logic [`SOT_COUNT_WIDTH-1:0] sot_count_type;
    typedef logic [`SOT_LAT_WIDTH-1:0] sot_latency_type;
    typedef logic [`SOT_SRC_WIDTH-1:0] sot_source_type;
    typedef logic [`SOT_QUAL_WIDTH-1:0] sot_qualifier_type;

    // Index of each derived event counter, as used on the read select
    typedef enum logic [`SOT_SEL_WIDTH-1:0] {
        SOT_EV_BRANCH = 6'h00,
        SOT_EV_BRANCH_MISP = 6'h01,
        SOT_EV_BRANCH_TAKEN = 6'h02,
        SOT_EV_BRANCH_TAKEN_MISP = 6'h03,
        SOT_EV_RETURN = 6'h04,
        SOT_EV_RETURN_MISP = 6'h05,
        SOT_EV_RESYNC = 6'h06,
        SOT_EV_MEM_OP = 6'h07,
        SOT_EV_LOAD = 6'h08,
        SOT_EV_STORE = 6'h09,
        SOT_EV_XL1_HIT = 6'h0A,
        SOT_EV_XL1_MISS_XL2_HIT = 6'h0B,
        SOT_EV_XL1_MISS_XL2_MISS = 6'h0C,
        SOT_EV_DC_MISS = 6'h0D,
        SOT_EV_DC_HIT = 6'h0E,
        SOT_EV_MISALIGNED = 6'h0F,
        SOT_EV_BANK_CONFLICT = 6'h10,
        SOT_EV_STORE_FWD = 6'h11,
        SOT_EV_FWD_CANCEL = 6'h12,
        SOT_EV_UNCACHED = 6'h13,
        SOT_EV_WRITE_COMB = 6'h14,
        SOT_EV_LOCKED = 6'h15,
        SOT_EV_MISS_BUF_HIT = 6'h16,
        SOT_EV_XL1_PAGE_4K = 6'h17,
        SOT_EV_XL1_PAGE_2M = 6'h18,
        SOT_EV_XL1_PAGE_1G = 6'h19,
        SOT_EV_XL2_PAGE_4K = 6'h1A,
        SOT_EV_XL2_PAGE_2M = 6'h1B,
        SOT_EV_MISS_LOAD_LAT = 6'h1C,
        SOT_EV_MC_LOCAL = 6'h1D,
        SOT_EV_MC_REMOTE = 6'h1E,
        SOT_EV_MC_LOCAL_SHARED = 6'h1F,
        SOT_EV_MC_LOCAL_CORE = 6'h20,
        SOT_EV_MC_REMOTE_CACHE = 6'h21,
        SOT_EV_MC_LOCAL_DRAM = 6'h22,
        SOT_EV_MC_REMOTE_DRAM = 6'h23,
        SOT_EV_MC_LOCAL_OTHER = 6'h24,
        SOT_EV_MC_REMOTE_OTHER = 6'h25,
        SOT_EV_MC_MODIFIED = 6'h26,
        SOT_EV_MC_OWNED = 6'h27,
        SOT_EV_MC_LOCAL_LAT = 6'h28,
        SOT_EV_MC_REMOTE_LAT = 6'h29
    } sot_event_type;

endpackage : sot_pkg

// ### hdl/sot_sat_accum.sv
// One saturating counter or latency sum
`include "sot_params.svh"

module sot_sat_accum (
    input wire logic clk,
    input wire logic reset,
    input wire logic addEnable,
    input wire sot_pkg::sot_count_type addValue,
    output sot_pkg::sot_count_type total
);
    import sot_pkg::*;

    // ------------------------------------------------------------
    // Saturating add
    // ------------------------------------------------------------
    logic [`SOT_COUNT_WIDTH:0] wideSum;
    sot_count_type next_total;

    // Carry out of the top bit pins the total at all ones
    assign wideSum = {1'h0, total} + {1'h0, addValue};
    assign next_total = wideSum[`SOT_COUNT_WIDTH] ? {`SOT_COUNT_WIDTH{1'h1}} :
                        wideSum[`SOT_COUNT_WIDTH-1:0];

    // Total register, cleared by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            total <= `SOT_COUNT_RESET;
        end else if (addEnable) begin
            total <= next_total;
        end
    end

endmodule : sot_sat_accum

// ### dv/sot_event_tally_chk.sv
// Port checker for the sampled op event tally
module sot_event_tally_chk
    import sot_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sampleValid,
    input wire logic opIsBranch,
    input wire logic branchMispredicted,
    input wire logic branchTaken,
    input wire logic opIsLoad,
    input wire logic opIsStore,
    input wire logic firstLevelXlatMiss,
    input wire logic secondLevelXlatMiss,
    input wire logic linearAddressValid,
    input wire logic dataCacheMiss,
    input wire logic secondLevelHit2mPage,
    input wire sot_pkg::sot_latency_type missLatencyCycles,
    input wire sot_pkg::sot_source_type memoryDataSource,
    input wire sot_pkg::sot_qualifier_type memorySourceQualifier,
    input wire logic remoteNodeRequest,
    input wire sot_pkg::sot_event_type countSelect,
    input wire sot_pkg::sot_count_type countValue
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Qualified sample conditions
    // ----------------------------------------------------------------
    wire logic missLoad = sampleValid & opIsLoad & dataCacheMiss;
    wire logic ctrlOk = missLoad & (memorySourceQualifier == 1'h0);
    wire logic l2Page = sampleValid & (opIsLoad | opIsStore) & linearAddressValid & firstLevelXlatMiss;
    wire logic l2Page4k = l2Page & ~secondLevelXlatMiss & ~secondLevelHit2mPage;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Totals read zero on the first two edges after reset
    reset_clears_a:
    assert property ($fell(reset) |-> countValue == 32'h0 ##1 countValue == 32'h0) else $error("total not cleared");
    out_of_range_a:
    assert property (countSelect > SOT_EV_MC_REMOTE_LAT |=> countValue == 32'h0) else $error("unused select not zero");
    never_falls_a:
    assert property ($stable(countSelect) |=> countValue >= $past(countValue)) else $error("total went down");
    // Exact step of a held total two edges after its sample
    branch_both_a:
    assert property (countSelect == SOT_EV_BRANCH_TAKEN_MISP ##1 $stable(countSelect) && countValue != 32'hFFFFFFFF
        |=> countValue == $past(countValue) + $past(sampleValid & opIsBranch & branchTaken & branchMispredicted, 2))
        else $error("taken mispredicted branch step wrong");
    l2_page4k_a:
    assert property (countSelect == SOT_EV_XL2_PAGE_4K ##1 $stable(countSelect) && countValue != 32'hFFFFFFFF
        |=> countValue == $past(countValue) + $past(l2Page4k, 2)) else $error("second level 4K step wrong");
    remote_dram_a:
    assert property (countSelect == SOT_EV_MC_REMOTE_DRAM ##1 $stable(countSelect) && countValue != 32'hFFFFFFFF
        |=> countValue == $past(countValue) + $past(ctrlOk & remoteNodeRequest & (memoryDataSource == 3'h3), 2))
        else $error("remote dram step wrong");
    miss_lat_sum_a:
    assert property (countSelect == SOT_EV_MISS_LOAD_LAT ##1 $stable(countSelect) && countValue < 32'hFFFF0000
        |=> countValue == $past(countValue) + ($past(missLoad, 2) ? $past(missLatencyCycles, 2) : 16'h0))
        else $error("miss load latency sum wrong");
    local_lat_a:
    assert property (countSelect == SOT_EV_MC_LOCAL_LAT ##1 $stable(countSelect) && countValue < 32'hFFFF0000
        |=> countValue == $past(countValue) + ($past(ctrlOk & ~remoteNodeRequest, 2) ? $past(missLatencyCycles, 2)
        : 16'h0)) else $error("local latency sum wrong");
endmodule : sot_event_tally_chk

bind sot_event_tally sot_event_tally_chk sot_event_tally_chk_i (.*);

// ### dv/sot_sample_src.sv
// Behavioural op sampling source, one sample per clock
module sot_sample_src (
    input wire logic clk,
    input wire logic [1:0] mode,
    output logic [45:0] smp
);
    timeunit 1ns;
    timeprecision 1ns;
    integer seed = 86973;
    logic [31:0] r0;
    logic [31:0] r1;

    // ----------------------------------------------------------------
    // Sample generation
    // ----------------------------------------------------------------
    initial smp = 46'h0;
    // Idle keeps fields moving so stale values never look valid; mode 2 is a worst-case missing load
    always @(posedge clk) begin
        r0 = $random(seed);
        r1 = $random(seed);
        case (mode)
            2'h1: smp <= {r0[23:0], r1[15:0], r1[18:16], r1[19] & r1[20], r1[22:21]};
            2'h2: smp <= {1'h1, 6'h00, 1'h1, 4'h0, 1'h1, 11'h000, 16'hFFFF, 3'h3, 3'h0};
            default: smp <= {1'h0, r0[22:0], r1[21:0]};
        endcase
    end
endmodule : sot_sample_src

// ### dv/sot_event_tally_tb_top.sv
// Self-checking testbench for the sampled op event tally
module sot_event_tally_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sot_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic sampleValid, opIsBranch, branchMispredicted, branchTaken, opIsReturn, returnMispredicted, opIsResync;
    logic opIsLoad, opIsStore, firstLevelXlatMiss, secondLevelXlatMiss, linearAddressValid, dataCacheMiss;
    logic misalignedAccess, loadBankConflict, storeForwardedToLoad, storeForwardCancelled, uncachedAccess;
    logic writeCombiningAccess, lockedOperation, missBufferHit, firstLevelHit2mPage, firstLevelHit1gPage;
    logic secondLevelHit2mPage, remoteNodeRequest, ownedStateHit, rdReq = 1'h0, rdLive = 1'h0;
    sot_latency_type missLatencyCycles;
    sot_source_type memoryDataSource;
    sot_qualifier_type memorySourceQualifier;
    sot_event_type countSelect = SOT_EV_BRANCH;
    sot_count_type countValue, exp, refCnt [0:41];
    sot_count_type expQ [$];
    logic [1:0] mode = 2'h0;
    logic [45:0] smp;
    logic [41:0] ev;
    logic [32:0] sum;
    int n_fail = 0;
    int comparisons = 0;

    // ----------------------------------------------------------------
    // Clock, partner and design
    // ----------------------------------------------------------------
    always #50 clk = ~clk;
    sot_sample_src sot_sample_src_i (.clk(clk), .mode(mode), .smp(smp));
    assign {sampleValid, opIsBranch, branchMispredicted, branchTaken, opIsReturn, returnMispredicted, opIsResync,
        opIsLoad, opIsStore, firstLevelXlatMiss, secondLevelXlatMiss, linearAddressValid, dataCacheMiss,
        misalignedAccess, loadBankConflict, storeForwardedToLoad, storeForwardCancelled, uncachedAccess,
        writeCombiningAccess, lockedOperation, missBufferHit, firstLevelHit2mPage, firstLevelHit1gPage,
        secondLevelHit2mPage, missLatencyCycles, memoryDataSource, memorySourceQualifier, remoteNodeRequest,
        ownedStateHit} = smp;
    sot_event_tally sot_event_tally_i (.*);

    // Expected event flags of the present sample, in select order
    function automatic logic [41:0] events();
        logic m, x, nb, r, l1, l2, c2;
        m = opIsLoad | opIsStore;
        x = m & linearAddressValid;
        nb = opIsLoad & dataCacheMiss & (memorySourceQualifier === 1'h0);
        r = remoteNodeRequest;
        l1 = firstLevelXlatMiss;
        l2 = secondLevelXlatMiss;
        c2 = nb & (memoryDataSource == 3'h2);
        return {nb & r, nb & ~r, c2 & ownedStateHit, c2 & ~ownedStateHit,
            {2{nb & (memoryDataSource == 3'h7)}} & {r, ~r}, {2{nb & (memoryDataSource == 3'h3)}} & {r, ~r},
            c2 & r, c2 & ~r, nb & (memoryDataSource == 3'h1) & ~r, nb & r, nb & ~r, opIsLoad & dataCacheMiss,
            x & l1 & ~l2 & secondLevelHit2mPage, x & l1 & ~l2 & ~secondLevelHit2mPage, x & firstLevelHit1gPage,
            x & firstLevelHit2mPage, x & ~firstLevelHit2mPage & ~firstLevelHit1gPage,
            {9{m}} & {missBufferHit, lockedOperation, writeCombiningAccess, uncachedAccess, storeForwardCancelled,
            storeForwardedToLoad, loadBankConflict, misalignedAccess, ~dataCacheMiss}, m & dataCacheMiss,
            m & l1 & l2, m & l1 & ~l2, x & ~l1, opIsStore, opIsLoad, m, opIsResync,
            opIsReturn & returnMispredicted, opIsReturn, {3{opIsBranch}} & {branchTaken & branchMispredicted,
            branchTaken, branchMispredicted}, opIsBranch};
    endfunction : events

    // Reference totals take each valid sample, saturating, and clear on reset
    always @(posedge clk) begin
        ev = events();
        for (int i = 0; i < 42; i++) begin
            sum = {1'h0, refCnt[i]} + ((i == 28 || i >= 40) ? {17'h0, missLatencyCycles} : 33'h1);
            if (reset)
                refCnt[i] = 32'h0;
            else if (sampleValid === 1'h1 && ev[i])
                refCnt[i] = sum[32] ? 32'hFFFFFFFF : sum[31:0];
        end
    end

    // Read every select back to back, noting what each should show
    task automatic read_all();
        for (int k = 0; k < 64; k++) begin
            @(posedge clk);
            countSelect <= sot_event_type'(k[5:0]);
            rdReq <= 1'h1;
            expQ.push_back(k < 42 ? refCnt[k] : 32'h0);
        end
        @(posedge clk);
        rdReq <= 1'h0;
        repeat (2) @(posedge clk);
    endtask : read_all

    // Compare each shown total with the oldest note
    always @(posedge clk) rdLive <= rdReq;
    always @(negedge clk) begin
        if (rdLive && expQ.size() > 0) begin
            exp = expQ.pop_front();
            comparisons++;
            if (countValue !== exp) begin
                n_fail++;
                $display("mismatch at %0t: total %h, expected %h", $time, countValue, exp);
            end
        end
    end

    // Print the counts and the verdict, then end the run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Random samples under each held select, mid-run reset, then saturation
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        mode <= 2'h1;
        for (int k = 0; k < 64; k++) begin
            countSelect <= sot_event_type'(k[5:0]);
            repeat (50) @(posedge clk);
        end
        mode <= 2'h0;
        repeat (3) @(posedge clk);
        read_all();
        mode <= 2'h1;
        repeat (20) @(posedge clk);
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        mode <= 2'h0;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge clk);
        read_all();
        mode <= 2'h2;
        repeat (65540) @(posedge clk);
        mode <= 2'h0;
        repeat (3) @(posedge clk);
        read_all();
        close_out();
    end
endmodule : sot_event_tally_tb_top
